//--- verilog/bit_error_rate_tester.sv
// per-port bit error rate tester with apb register access
`timescale 1ns/1ps

// Function
// - send chosen pattern on the port and measure the returned bit error ratio
// - patterns: off, ones, zeros, 1010, 0100-0000, 511, 2047, quasi-random
// - reset configuration: pattern off, toward network, main channel
// - network direction sends toward the network; user sends to four-wire line
// - pattern goes on main or auxiliary channel; auxiliary only if present
// - read-only lock flag shows the checker is synchronised to the pattern
// - bit error tally counts every received bit that mismatches while the checker is locked
// - errored-second tally counts seconds with at least one error
// - severe-second tally counts seconds with error ratio above one per thousand
// - after ten severe seconds count every second until ten clean seconds
// - unlocked-second tally counts seconds in which the checker lacked lock
// - error ratio is error tally divided by bits sent since the start
// - runtime counts whole seconds since the test started
// - four-wire line state shows normal when signal present, else no signal
// - one inject command inverts exactly one transmitted pattern bit
// - readable statistics change only when a refresh is commanded
// - settings are staged; save commits them into effect
// - undo drops staged settings back to the last committed values
module bit_error_rate_tester
  import bert_pkg::*;
#(
  parameter int SECOND_CYCLES_P = SECOND_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_bit_en,
  output logic net_tx_bit,
  output logic net_tx_valid,
  output logic user_tx_bit,
  output logic user_tx_valid,
  output logic aux_channel_sel,
  input wire logic net_rx_bit,
  input wire logic net_rx_valid,
  input wire logic user_rx_bit,
  input wire logic user_rx_valid,
  input wire logic aux_channel_present,
  input wire logic line_signal_present
);

  // next bit of a pattern from its own history, newest bit in h[0]
  function automatic logic pattern_bit(input pattern_t p, input logic [HIST_W-1:0] h);
    case (p)
      PAT_MARK: pattern_bit = 1'b1;
      PAT_SPACE: pattern_bit = 1'b0;
      PAT_ALT: pattern_bit = ~h[0];
      PAT_ONE_IN_8: pattern_bit = h[7];
      PAT_PRBS9: pattern_bit = h[8] ^ h[4];
      PAT_PRBS11: pattern_bit = h[10] ^ h[8];
      PAT_QRSS: pattern_bit = h[19] ^ h[16];
      default: pattern_bit = 1'b0;
    endcase
  endfunction

  cfg_t staged_q;
  cfg_t active_q;
  logic setup;
  logic wr_access;
  logic cmd_wr;
  logic save_cmd;
  logic undo_cmd;
  logic refresh_cmd;
  logic inject_cmd;
  logic restart;
  logic running;
  cfg_t wr_cfg;
  logic [HIST_W-1:0] tx_hist_q;
  logic tx_next;
  logic inject_pend_q;
  logic [31:0] tx_bits_q;
  logic [31:0] bit_err_q;
  logic rx_bit;
  logic rx_valid;
  logic [HIST_W-1:0] rx_hist_q;
  logic mismatch;
  logic sync_q;
  logic [5:0] good_run_q;
  logic [5:0] win_pos_q;
  logic [5:0] win_err_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [31:0] sec_err_q;
  logic [31:0] sec_bits_q;
  logic sec_unlocked_q;
  logic severe;
  logic [31:0] err_sec_q;
  logic [31:0] sev_sec_q;
  logic [31:0] run_sec_q;
  logic [31:0] unlk_sec_q;
  logic [31:0] runtime_q;
  logic [3:0] sev_streak_q;
  logic [3:0] ok_streak_q;
  logic in_run_q;
  logic [31:0] snap_err_q;
  logic [31:0] snap_es_q;
  logic [31:0] snap_ses_q;
  logic [31:0] snap_run_q;
  logic [31:0] snap_unlk_q;
  logic [31:0] snap_time_q;
  logic [31:0] snap_bits_q;
  logic [31:0] ratio_q;
  div_state_t div_state_q;
  logic [5:0] div_step_q;
  logic [32:0] div_rem_q;
  logic [32:0] div_shift;
  logic [31:0] div_den_q;
  logic [31:0] div_quo_q;
  logic [31:0] rd_val;
  logic rd_hit;

  // apb: decode in setup, answer with zero wait states in the access phase
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign pready = 1'b1;
  assign cmd_wr = wr_access && (paddr == OFS_CMD);
  assign save_cmd = cmd_wr && pwdata[CMD_SAVE];
  assign undo_cmd = cmd_wr && pwdata[CMD_UNDO] && !pwdata[CMD_SAVE];
  assign refresh_cmd = cmd_wr && pwdata[CMD_REFRESH];
  assign inject_cmd = cmd_wr && pwdata[CMD_INJECT];
  assign wr_cfg = '{pattern: pattern_t'(pwdata[FLD_PATTERN_LSB +: 3]), dir: dir_t'(pwdata[FLD_DIR]),
                    chan: chan_t'(pwdata[FLD_CHAN])};

  always_comb
  begin
    rd_hit = 1'b1;
    case (paddr)
      OFS_STAGED: rd_val = {23'h0, staged_q.chan, 3'h0, staged_q.dir, 1'h0, staged_q.pattern};
      OFS_ACTIVE: rd_val = {23'h0, active_q.chan, 3'h0, active_q.dir, 1'h0, active_q.pattern};
      OFS_CMD: rd_val = 32'h0;
      OFS_STATUS: rd_val = {27'h0, inject_pend_q, div_state_q == DIV_RUN, aux_channel_present,
                            line_signal_present, sync_q};
      OFS_BIT_ERR: rd_val = snap_err_q;
      OFS_ERR_SEC: rd_val = snap_es_q;
      OFS_SEV_SEC: rd_val = snap_ses_q;
      OFS_RUN_SEC: rd_val = snap_run_q;
      OFS_UNLK_SEC: rd_val = snap_unlk_q;
      OFS_RUNTIME: rd_val = snap_time_q;
      OFS_RATIO: rd_val = ratio_q;
      OFS_TX_BITS: rd_val = snap_bits_q;
      default:
      begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata <= pwrite ? 32'h0 : rd_val;
      pslverr <= !rd_hit;
    end
  end

  // staged and committed settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      staged_q <= CFG_RESET;
    else if (wr_access && paddr == OFS_STAGED)
      staged_q <= wr_cfg;
    else if (undo_cmd)
      staged_q <= active_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_q <= CFG_RESET;
    else if (save_cmd)
    begin
      active_q <= staged_q;
      active_q.chan <= aux_channel_present ? staged_q.chan : CHAN_MAIN;
    end
  end

  // a committed pattern change starts a new test
  assign restart = (save_cmd && staged_q.pattern != active_q.pattern) || (cmd_wr && pwdata[CMD_CLEAR]);
  assign running = active_q.pattern != PAT_OFF;
  assign aux_channel_sel = active_q.chan == CHAN_AUX;

  // transmit generator; history keeps the clean bit so an injected error stays single
  assign tx_next = pattern_bit(active_q.pattern, tx_hist_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_hist_q <= TX_SEED;
    else if (restart)
      tx_hist_q <= TX_SEED;
    else if (tx_bit_en && running)
      tx_hist_q <= {tx_hist_q[HIST_W-2:0], tx_next};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      inject_pend_q <= 1'b0;
    else if (inject_cmd && running)
      inject_pend_q <= 1'b1;
    else if (tx_bit_en || !running)
      inject_pend_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      net_tx_bit <= 1'b0;
      net_tx_valid <= 1'b0;
      user_tx_bit <= 1'b0;
      user_tx_valid <= 1'b0;
    end
    else
    begin
      net_tx_valid <= tx_bit_en && running && active_q.dir == DIR_NET;
      user_tx_valid <= tx_bit_en && running && active_q.dir == DIR_USER;
      if (tx_bit_en && running)
      begin
        net_tx_bit <= tx_next ^ inject_pend_q;
        user_tx_bit <= tx_next ^ inject_pend_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_bits_q <= 32'h0;
    else if (restart)
      tx_bits_q <= 32'h0;
    else if (tx_bit_en && running)
      tx_bits_q <= tx_bits_q + 32'h1;
  end

  // receive checker: the return path is the side the pattern was sent to
  assign rx_bit = (active_q.dir == DIR_NET) ? net_rx_bit : user_rx_bit;
  assign rx_valid = running && ((active_q.dir == DIR_NET) ? net_rx_valid : user_rx_valid);
  assign mismatch = rx_valid && (pattern_bit(active_q.pattern, rx_hist_q) != rx_bit);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_hist_q <= '0;
    else if (rx_valid)
      rx_hist_q <= {rx_hist_q[HIST_W-2:0], rx_bit};
  end

  // lock after a clean run; drop lock on a burst of errors inside a window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_q <= 1'b0;
      good_run_q <= 6'h0;
      win_pos_q <= 6'h0;
      win_err_q <= 6'h0;
    end
    else if (restart || !running)
    begin
      sync_q <= 1'b0;
      good_run_q <= 6'h0;
      win_pos_q <= 6'h0;
      win_err_q <= 6'h0;
    end
    else if (rx_valid)
    begin
      if (!sync_q)
      begin
        good_run_q <= mismatch ? 6'h0 : good_run_q + 6'h1;
        if (!mismatch && good_run_q == SYNC_GOOD_BITS - 6'h1)
          sync_q <= 1'b1;
        win_pos_q <= 6'h0;
        win_err_q <= 6'h0;
      end
      else
      begin
        win_pos_q <= win_pos_q + 6'h1;
        if (mismatch && win_err_q == LOSS_ERRORS - 6'h1)
        begin
          sync_q <= 1'b0;
          good_run_q <= 6'h0;
        end
        if (win_pos_q == LOSS_WINDOW_LAST)
          win_err_q <= 6'h0;
        else if (mismatch)
          win_err_q <= win_err_q + 6'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_err_q <= 32'h0;
    else if (restart)
      bit_err_q <= 32'h0;
    else if (mismatch && sync_q)
      bit_err_q <= bit_err_q + 32'h1;
  end

  // common one-second tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_q <= 32'h0;
    else if (restart || tick)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  assign tick = running && (tick_cnt_q == 32'(SECOND_CYCLES_P - 1));

  // accumulation inside the current second; an event on the tick opens the next one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_err_q <= 32'h0;
      sec_bits_q <= 32'h0;
      sec_unlocked_q <= 1'b0;
    end
    else if (restart || tick)
    begin
      sec_err_q <= {31'h0, mismatch && sync_q};
      sec_bits_q <= {31'h0, rx_valid && sync_q};
      sec_unlocked_q <= !sync_q;
    end
    else
    begin
      if (mismatch && sync_q)
        sec_err_q <= sec_err_q + 32'h1;
      if (rx_valid && sync_q)
        sec_bits_q <= sec_bits_q + 32'h1;
      if (!sync_q)
        sec_unlocked_q <= 1'b1;
    end
  end

  assign severe = ({10'h0, sec_err_q} * SEVERE_RATIO) > {10'h0, sec_bits_q};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_sec_q <= 32'h0;
      sev_sec_q <= 32'h0;
      unlk_sec_q <= 32'h0;
      runtime_q <= 32'h0;
    end
    else if (restart)
    begin
      err_sec_q <= 32'h0;
      sev_sec_q <= 32'h0;
      unlk_sec_q <= 32'h0;
      runtime_q <= 32'h0;
    end
    else if (tick)
    begin
      runtime_q <= runtime_q + 32'h1;
      if (sec_err_q != 32'h0)
        err_sec_q <= err_sec_q + 32'h1;
      if (severe)
        sev_sec_q <= sev_sec_q + 32'h1;
      if (sec_unlocked_q)
        unlk_sec_q <= unlk_sec_q + 32'h1;
    end
  end

  // consecutive severe run: the tenth severe second opens it, ten clean seconds close it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sev_streak_q <= 4'h0;
      ok_streak_q <= 4'h0;
      in_run_q <= 1'b0;
      run_sec_q <= 32'h0;
    end
    else if (restart)
    begin
      sev_streak_q <= 4'h0;
      ok_streak_q <= 4'h0;
      in_run_q <= 1'b0;
      run_sec_q <= 32'h0;
    end
    else if (tick)
    begin
      sev_streak_q <= severe ? ((sev_streak_q == RUN_SECONDS) ? RUN_SECONDS : sev_streak_q + 4'h1) : 4'h0;
      ok_streak_q <= severe ? 4'h0 : ((ok_streak_q == RUN_SECONDS) ? RUN_SECONDS : ok_streak_q + 4'h1);
      if (!in_run_q && severe && sev_streak_q == RUN_SECONDS - 4'h1)
      begin
        in_run_q <= 1'b1;
        run_sec_q <= run_sec_q + 32'h1;
      end
      else if (in_run_q && !severe && ok_streak_q == RUN_SECONDS - 4'h1)
        in_run_q <= 1'b0;
      else if (in_run_q)
        run_sec_q <= run_sec_q + 32'h1;
    end
  end

  // snapshots seen by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_err_q <= 32'h0;
      snap_es_q <= 32'h0;
      snap_ses_q <= 32'h0;
      snap_run_q <= 32'h0;
      snap_unlk_q <= 32'h0;
      snap_time_q <= 32'h0;
      snap_bits_q <= 32'h0;
    end
    else if (refresh_cmd)
    begin
      snap_err_q <= bit_err_q;
      snap_es_q <= err_sec_q;
      snap_ses_q <= sev_sec_q;
      snap_run_q <= run_sec_q;
      snap_unlk_q <= unlk_sec_q;
      snap_time_q <= runtime_q;
      snap_bits_q <= tx_bits_q;
    end
  end

  // error ratio as a 32-bit binary fraction, serial division to save area
  assign div_shift = {div_rem_q[31:0], 1'b0};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_state_q <= DIV_IDLE;
      div_step_q <= 6'h0;
      div_rem_q <= 33'h0;
      div_den_q <= 32'h0;
      div_quo_q <= 32'h0;
      ratio_q <= 32'h0;
    end
    else
    begin
      case (div_state_q)
        DIV_IDLE:
        begin
          if (refresh_cmd)
          begin
            if (tx_bits_q == 32'h0)
              ratio_q <= 32'h0;
            else if (bit_err_q >= tx_bits_q)
              ratio_q <= 32'hFFFFFFFF;
            else
            begin
              div_state_q <= DIV_RUN;
              div_rem_q <= {1'b0, bit_err_q};
              div_den_q <= tx_bits_q;
              div_step_q <= 6'h0;
            end
          end
        end
        DIV_RUN:
        begin
          if (div_shift >= {1'b0, div_den_q})
          begin
            div_rem_q <= div_shift - {1'b0, div_den_q};
            div_quo_q <= {div_quo_q[30:0], 1'b1};
          end
          else
          begin
            div_rem_q <= div_shift;
            div_quo_q <= {div_quo_q[30:0], 1'b0};
          end
          div_step_q <= div_step_q + 6'h1;
          if (div_step_q == DIV_STEPS - 6'h1)
          begin
            div_state_q <= DIV_IDLE;
            ratio_q <= (div_shift >= {1'b0, div_den_q}) ? {div_quo_q[30:0], 1'b1} : {div_quo_q[30:0], 1'b0};
          end
        end
        default: div_state_q <= DIV_IDLE;
      endcase
    end
  end

endmodule

//--- verilog/bert_pkg.sv
// shared constants, types and register map of the bit error rate tester
package bert_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_STAGED = 8'h00;
  localparam logic [7:0] OFS_ACTIVE = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_BIT_ERR = 8'h10;
  localparam logic [7:0] OFS_ERR_SEC = 8'h14;
  localparam logic [7:0] OFS_SEV_SEC = 8'h18;
  localparam logic [7:0] OFS_RUN_SEC = 8'h1C;
  localparam logic [7:0] OFS_UNLK_SEC = 8'h20;
  localparam logic [7:0] OFS_RUNTIME = 8'h24;
  localparam logic [7:0] OFS_RATIO = 8'h28;
  localparam logic [7:0] OFS_TX_BITS = 8'h2C;

  // field positions
  localparam int FLD_PATTERN_LSB = 0;
  localparam int FLD_DIR = 4;
  localparam int FLD_CHAN = 8;
  localparam int CMD_SAVE = 0;
  localparam int CMD_UNDO = 1;
  localparam int CMD_REFRESH = 2;
  localparam int CMD_INJECT = 3;
  localparam int CMD_CLEAR = 4;
  localparam int ST_SYNC = 0;
  localparam int ST_LINE = 1;
  localparam int ST_SEC_AVAIL = 2;
  localparam int ST_RATIO_BUSY = 3;
  localparam int ST_INJECT_PEND = 4;

  typedef enum logic [2:0] {
    PAT_OFF = 3'b000,
    PAT_MARK = 3'b001,
    PAT_SPACE = 3'b010,
    PAT_ALT = 3'b011,
    PAT_ONE_IN_8 = 3'b100,
    PAT_PRBS9 = 3'b101,
    PAT_PRBS11 = 3'b110,
    PAT_QRSS = 3'b111
  } pattern_t;

  typedef enum logic {
    DIR_NET = 1'b0,
    DIR_USER = 1'b1
  } dir_t;

  typedef enum logic {
    CHAN_MAIN = 1'b0,
    CHAN_AUX = 1'b1
  } chan_t;

  typedef enum logic {
    DIV_IDLE = 1'b0,
    DIV_RUN = 1'b1
  } div_state_t;

  typedef struct packed {
    pattern_t pattern;
    dir_t dir;
    chan_t chan;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{pattern: PAT_OFF, dir: DIR_NET, chan: CHAN_MAIN};

  // pattern history, seeded so the one-in-eight byte and the sequences start non-zero
  localparam int HIST_W = 20;
  localparam logic [19:0] TX_SEED = 20'h00040;

  // receive lock: consecutive good bits to lock, errors per window to drop lock
  localparam logic [5:0] SYNC_GOOD_BITS = 6'h20;
  localparam logic [5:0] LOSS_ERRORS = 6'h10;
  localparam logic [5:0] LOSS_WINDOW_LAST = 6'h3F;

  // per-second statistics
  localparam int SECOND_NS = 1000000000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [41:0] SEVERE_RATIO = 42'h000_0000_03E8;
  localparam logic [3:0] RUN_SECONDS = 4'hA;
  localparam logic [5:0] DIV_STEPS = 6'h20;

endpackage

//--- tb/bert_sva.sv
// concurrent checks on the tester's bus and line ports
`timescale 1ns/1ps
module bert_sva
  import bert_pkg::*;
#(
  parameter int SECOND_CYCLES_P = SECOND_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_bit_en,
  input wire logic net_tx_bit,
  input wire logic net_tx_valid,
  input wire logic user_tx_bit,
  input wire logic user_tx_valid,
  input wire logic aux_channel_sel,
  input wire logic net_rx_bit,
  input wire logic net_rx_valid,
  input wire logic user_rx_bit,
  input wire logic user_rx_valid,
  input wire logic aux_channel_present,
  input wire logic line_signal_present
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_always_a: assert property (pready) else $error("pready low");
  net_slot_a: assert property (net_tx_valid |-> $past(tx_bit_en)) else $error("net bit without slot");
  user_slot_a: assert property (user_tx_valid |-> $past(tx_bit_en)) else $error("user bit without slot");
  one_side_a: assert property (!(net_tx_valid && user_tx_valid)) else $error("both sides sending");
  aux_gate_a: assert property ($rose(aux_channel_sel) |-> $past(aux_channel_present))
    else $error("aux chosen while absent");
  map_ok_a: assert property (psel && penable && paddr <= 8'h2C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped address");
  map_err_a: assert property (psel && penable && (paddr > 8'h2C || paddr[1:0] != 2'b00)
    |-> pslverr && prdata == 32'h0) else $error("unmapped address accepted");
  cmd_zero_a: assert property (psel && !penable && !pwrite && paddr == OFS_CMD |=> prdata == 32'h0)
    else $error("command register read nonzero");
endmodule

bind bit_error_rate_tester bert_sva #(.SECOND_CYCLES_P(SECOND_CYCLES_P)) checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_bit_en(tx_bit_en),
  .net_tx_bit(net_tx_bit), .net_tx_valid(net_tx_valid), .user_tx_bit(user_tx_bit),
  .user_tx_valid(user_tx_valid), .aux_channel_sel(aux_channel_sel), .net_rx_bit(net_rx_bit),
  .net_rx_valid(net_rx_valid), .user_rx_bit(user_rx_bit), .user_rx_valid(user_rx_valid),
  .aux_channel_present(aux_channel_present), .line_signal_present(line_signal_present));

//--- tb/far_end_loop.sv
// far end looped back, with optional periodic bit corruption
`timescale 1ns/1ps
module far_end_loop (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_bit,
  input wire logic tx_valid,
  input wire logic [7:0] flip_every,
  output logic rx_bit,
  output logic rx_valid
);
  logic [7:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q <= 8'h00;
      rx_bit <= 1'b0;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= tx_valid;
      // between bits the line shows the inverse, so a stale level never passes for data
      rx_bit <= tx_valid ? tx_bit ^ (flip_every != 8'h00 && cnt_q == flip_every) : ~rx_bit;
      if (tx_valid)
        cnt_q <= (cnt_q >= flip_every) ? 8'h00 : cnt_q + 8'h01;
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the bit error rate tester
`timescale 1ns/1ps
module testbench
  import bert_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, b0, b1;
  logic [31:0] s [8];
  logic pready, pslverr, err, d, b, tx_bit_en = 1'b0, aux_channel_present = 1'b0, line_signal_present = 1'b1;
  logic net_tx_bit, net_tx_valid, user_tx_bit, user_tx_valid, aux_channel_sel;
  logic net_rx_bit, net_rx_valid, user_rx_bit, user_rx_valid;
  logic [7:0] flip_every = 8'h00;
  logic [19:0] hist = 20'h0;
  pattern_t pat = PAT_OFF;
  int num_errors = 0, checked = 0, cyc_cnt = 0, t0, nseen = 0, nnet = 0, nuser = 0, tx_mis = 0;

  bit_error_rate_tester #(.SECOND_CYCLES_P(1000)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_bit_en(tx_bit_en), .net_tx_bit(net_tx_bit), .net_tx_valid(net_tx_valid),
    .user_tx_bit(user_tx_bit), .user_tx_valid(user_tx_valid), .aux_channel_sel(aux_channel_sel),
    .net_rx_bit(net_rx_bit), .net_rx_valid(net_rx_valid), .user_rx_bit(user_rx_bit),
    .user_rx_valid(user_rx_valid), .aux_channel_present(aux_channel_present),
    .line_signal_present(line_signal_present));
  far_end_loop net_far (.pclk(pclk), .presetn(presetn), .tx_bit(net_tx_bit), .tx_valid(net_tx_valid),
    .flip_every(flip_every), .rx_bit(net_rx_bit), .rx_valid(net_rx_valid));
  far_end_loop user_far (.pclk(pclk), .presetn(presetn), .tx_bit(user_tx_bit), .tx_valid(user_tx_valid),
    .flip_every(flip_every), .rx_bit(user_rx_bit), .rx_valid(user_rx_valid));

  initial
  begin
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
    cyc_cnt <= cyc_cnt + 1;

  // next bit from the last twenty sent, h[0] being the newest
  function automatic logic predict(input logic [19:0] h, input pattern_t p);
    case (p)
      PAT_MARK: return 1'b1;
      PAT_SPACE: return 1'b0;
      PAT_ALT: return ~h[0];
      PAT_ONE_IN_8: return h[7];
      PAT_PRBS9: return h[8] ^ h[4];
      PAT_PRBS11: return h[10] ^ h[8];
      default: return h[19] ^ h[16];
    endcase
  endfunction

  function automatic logic [31:0] ratio(input logic [31:0] e, input logic [31:0] n);
    if (n == 32'h0)
      return 32'h0;
    if (e >= n)
      return 32'hFFFFFFFF;
    return 32'({e, 32'h0} / n);
  endfunction

  function automatic logic [31:0] cfg_word(input int p, input int dr, input int c);
    return (c << FLD_CHAN) | (dr << FLD_DIR) | (p << FLD_PATTERN_LSB);
  endfunction

  // history keeps the predicted bit, so one inverted bit is counted once
  always @(posedge pclk)
    if (net_tx_valid || user_tx_valid)
    begin
      b = net_tx_valid ? net_tx_bit : user_tx_bit;
      nnet += net_tx_valid;
      nuser += user_tx_valid;
      if (nseen >= 20 && b !== predict(hist, pat))
        tx_mis++;
      hist = {hist[18:0], nseen >= 20 ? predict(hist, pat) : b};
      nseen++;
    end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic wait_to(input int t);
    while (cyc_cnt < t) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic stats;
    apb(1'b1, OFS_CMD, 1 << CMD_REFRESH);
    do
      apb(1'b0, OFS_STATUS, 32'h0);
    while (rd[ST_RATIO_BUSY] !== 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(OFS_BIT_ERR + 4 * i), 32'h0);
      s[i] = rd;
    end
  endtask

  task automatic clear_run;
    apb(1'b1, OFS_CMD, 1 << CMD_CLEAR);
    t0 = cyc_cnt;
    // a restart reseeds the generator, so the reference history is rebuilt from the line
    cyc(1);
    nseen = 0;
  endtask

  task automatic tally_and_finish;
    $display("errors %0d of %0d checks", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    void'($urandom(83));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(OFS_STAGED, 32'h0);
    rdchk(OFS_ACTIVE, 32'h0);
    v = cfg_word($urandom_range(7, 1), $urandom_range(1, 0), 1);
    apb(1'b1, OFS_STAGED, v);
    rdchk(OFS_ACTIVE, 32'h0);
    apb(1'b1, OFS_CMD, 1 << CMD_UNDO);
    rdchk(OFS_STAGED, 32'h0);
    apb(1'b1, OFS_STAGED, v);
    apb(1'b1, OFS_CMD, 1 << CMD_SAVE);
    rdchk(OFS_ACTIVE, v & 32'hFFFFFEFF);
    aux_channel_present <= 1'b1;
    apb(1'b1, OFS_CMD, 1 << CMD_SAVE);
    rdchk(OFS_ACTIVE, v);
    check(aux_channel_sel, 1);
    apb(1'b0, 8'h30, 32'h0);
    check(err, 1);
    rdchk(OFS_CMD, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      line_signal_present <= i[0];
      cyc(3);
      apb(1'b0, OFS_STATUS, 32'h0);
      check(rd[ST_LINE], i);
    end
    tx_bit_en <= 1'b1;
    for (int p = 0; p < 8; p++)
    begin
      d = 1'($urandom_range(1, 0));
      apb(1'b1, OFS_STAGED, cfg_word(p, d, 0));
      apb(1'b1, OFS_CMD, 1 << CMD_SAVE);
      cyc(2);
      pat = pattern_t'(p);
      nseen = 0;
      nnet = 0;
      nuser = 0;
      tx_mis = 0;
      cyc(60);
      check(tx_mis, 0);
      check({nnet == 0, nuser == 0}, p == 0 ? 2'b11 : (d ? 2'b10 : 2'b01));
    end
    // a loop that never locks
    flip_every <= 8'h01;
    clear_run();
    wait_to(t0 + 3500);
    stats();
    check(s[4], 3);
    check(s[5], 3);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd[ST_SYNC], 0);
    flip_every <= 8'h00;
    cyc(200);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd[ST_SYNC], 1);
    clear_run();
    wait_to(t0 + 1200);
    stats();
    b0 = s[0];
    b1 = s[1];
    tx_mis = 0;
    apb(1'b1, OFS_CMD, 1 << CMD_INJECT);
    wait_to(t0 + 2500);
    check(tx_mis, 1);
    rdchk(OFS_BIT_ERR, b0);
    stats();
    // the self-synchronising checker sees the bad bit again at both feedback taps
    check(s[0] - b0, 3);
    check(s[1] - b1, 1);
    check(s[5], 2);
    check(s[6], ratio(s[0], s[7]));
    // errors only count while locked, so the loop turns lossy once the checker has locked
    clear_run();
    cyc(100);
    flip_every <= 8'h2F;
    wait_to(t0 + 11500);
    flip_every <= 8'h00;
    wait_to(t0 + 12500);
    stats();
    check(s[2], 12);
    check(s[3], 3);
    b0 = s[0];
    cyc(600);
    rdchk(OFS_BIT_ERR, b0);
    wait_to(t0 + 24500);
    stats();
    check(s[2], 12);
    check(s[3], 12);
    tally_and_finish();
  end
endmodule
